/* src/led_pkg.sv */
package led_pkg;
    // Slave state machine codes
    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_PREOP = 3'h2,
        ST_BOOT = 3'h3,
        ST_SAFEOP = 3'h4,
        ST_OP = 3'h0
    } slave_state_e;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFS = 4'hc;

    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_STATE_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0011;

    // Interrupt bits
    localparam int IRQ_WARN_BIT = 0;
    localparam int IRQ_ERR_A_BIT = 1;
    localparam int IRQ_ERR_B_BIT = 2;
    localparam int IRQ_STATE_BIT = 3;
    localparam int IRQ_WIDTH = 4;

    // Pattern timing
    localparam int CLK_HZ = 50_000_000;
    localparam int BLINK_HALF_MS = 200;
    localparam int FLASH_ON_MS = 200;
    localparam int FLASH_PERIOD_MS = 1200;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

    typedef struct packed {
        logic enc_ready;
        logic enc_a;
        logic enc_b;
        logic enc_c;
        logic latch;
        logic in1;
        logic in2;
        logic drv_ready;
        logic supply_ok;
        logic cw;
        logic ccw;
        logic mod_ready;
        logic overtemp_warn;
        logic duty_full;
        logic fault_a;
        logic fault_b;
    } status_s;

    typedef struct packed {
        logic run;
        logic enc;
        logic a;
        logic b;
        logic c;
        logic latch;
        logic in1;
        logic in2;
        logic drv;
        logic pwr;
        logic cw;
        logic ccw;
        logic en;
        logic warn;
        logic err_a;
        logic err_b;
    } leds_s;
endpackage

/* src/status_led_driver.sv */
`timescale 1ns/100ps
module status_led_driver #(
    parameter int TICK_CYCLES = led_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Status from pins and other logic
    input wire led_pkg::status_s status_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Indicators and side outputs
    output led_pkg::leds_s leds_o,
    output logic outputs_safe_o,
    output logic irq_o
);
    led_pkg::status_s sync1_q;
    led_pkg::status_s sync2_q;
    logic [31:0] ctrl_q;
    logic [led_pkg::IRQ_WIDTH-1:0] irq_stat_q;
    logic [led_pkg::IRQ_WIDTH-1:0] irq_mask_q;
    logic [led_pkg::IRQ_WIDTH-1:0] evt_d;
    logic [led_pkg::IRQ_WIDTH-1:0] evt_lvl_q;
    logic [31:0] tick_cnt_q;
    logic [10:0] ms_q;
    logic ack_q;
    logic motor_en;
    logic [2:0] state;
    logic [2:0] state_prev_q;
    logic blink;
    logic flash;
    logic run_d;
    logic warn_d;
    // One flop per lamp, packed only at the port
    logic run_q;
    logic enc_q;
    logic trk_a_q;
    logic trk_b_q;
    logic trk_c_q;
    logic latch_q;
    logic in1_q;
    logic in2_q;
    logic drv_q;
    logic pwr_q;
    logic cw_q;
    logic ccw_q;
    logic en_q;
    logic warn_q;
    logic err_a_q;
    logic err_b_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pins are asynchronous to the core clock
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= status_i;
            sync2_q <= sync1_q;
        end
    end

    assign motor_en = ctrl_q[led_pkg::CTRL_ENABLE_BIT];
    assign state = ctrl_q[led_pkg::CTRL_STATE_LSB +: 3];

    // Millisecond prescaler and pattern phase
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_cnt_q <= '0;
            ms_q <= '0;
        end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            ms_q <= (ms_q == 11'(led_pkg::FLASH_PERIOD_MS - 1)) ? '0 : ms_q + 11'h1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    // Blink is 200 ms on/off; flash is 200 ms on in 1200 ms
    assign blink = ((ms_q / 11'(led_pkg::BLINK_HALF_MS)) % 11'h2) == 11'h0;
    assign flash = ms_q < 11'(led_pkg::FLASH_ON_MS);

    always_comb begin
        unique case (state)
            led_pkg::ST_PREOP: run_d = blink;
            led_pkg::ST_SAFEOP: run_d = flash;
            led_pkg::ST_OP: run_d = 1'b1;
            default: run_d = 1'b0;
        endcase
    end

    assign warn_d = !sync2_q.supply_ok || sync2_q.overtemp_warn || sync2_q.duty_full;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            outputs_safe_o <= 1'b1;
        end else begin
            outputs_safe_o <= state != led_pkg::ST_OP;
        end
    end

    // Run lamp pattern follows the state field
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enc_q <= 1'b0;
        end else begin
            enc_q <= sync2_q.enc_ready;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trk_a_q <= 1'b0;
        end else begin
            trk_a_q <= sync2_q.enc_a;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trk_b_q <= 1'b0;
        end else begin
            trk_b_q <= sync2_q.enc_b;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trk_c_q <= 1'b0;
        end else begin
            trk_c_q <= sync2_q.enc_c;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= sync2_q.latch;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in1_q <= 1'b0;
        end else begin
            in1_q <= sync2_q.in1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in2_q <= 1'b0;
        end else begin
            in2_q <= sync2_q.in2;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drv_q <= 1'b0;
        end else begin
            drv_q <= sync2_q.drv_ready;
        end
    end

    // Power and enable lamps are gated by the software enable bit
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwr_q <= 1'b0;
        end else begin
            pwr_q <= sync2_q.supply_ok && motor_en;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cw_q <= 1'b0;
        end else begin
            cw_q <= sync2_q.cw;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ccw_q <= 1'b0;
        end else begin
            ccw_q <= sync2_q.ccw;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_q <= 1'b0;
        end else begin
            en_q <= motor_en && sync2_q.mod_ready;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            warn_q <= 1'b0;
        end else begin
            warn_q <= warn_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_a_q <= 1'b0;
        end else begin
            err_a_q <= sync2_q.fault_a;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_b_q <= 1'b0;
        end else begin
            err_b_q <= sync2_q.fault_b;
        end
    end

    // Plain wiring, so every lamp still comes straight from its flop
    assign leds_o = {
        run_q,
        enc_q,
        trk_a_q,
        trk_b_q,
        trk_c_q,
        latch_q,
        in1_q,
        in2_q,
        drv_q,
        pwr_q,
        cw_q,
        ccw_q,
        en_q,
        warn_q,
        err_a_q,
        err_b_q
    };

    // Rising edges of fault levels and any state change raise events
    always_comb begin
        evt_d = '0;
        evt_d[led_pkg::IRQ_WARN_BIT] = warn_d && !evt_lvl_q[led_pkg::IRQ_WARN_BIT];
        evt_d[led_pkg::IRQ_ERR_A_BIT] = sync2_q.fault_a && !evt_lvl_q[led_pkg::IRQ_ERR_A_BIT];
        evt_d[led_pkg::IRQ_ERR_B_BIT] = sync2_q.fault_b && !evt_lvl_q[led_pkg::IRQ_ERR_B_BIT];
        evt_d[led_pkg::IRQ_STATE_BIT] = state != state_prev_q;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            evt_lvl_q <= '0;
            state_prev_q <= led_pkg::CTRL_RESET[led_pkg::CTRL_STATE_LSB +: 3];
        end else begin
            evt_lvl_q <= {1'b0, sync2_q.fault_b, sync2_q.fault_a, warn_d};
            state_prev_q <= state;
        end
    end

    // One wait cycle per access, so every access ends on the second edge
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end

    // Registered port, so it stays high while the bus is idle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= led_pkg::CTRL_RESET;
        end else if (avs_write_i && ack_q && avs_address_i == led_pkg::CTRL_OFS) begin
            ctrl_q <= merge(ctrl_q, avs_writedata_i, avs_byteenable_i) & 32'h0000_0071;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_mask_q <= '0;
        end else if (avs_write_i && ack_q && avs_address_i == led_pkg::IRQ_MASK_OFS && avs_byteenable_i[0]) begin
            irq_mask_q <= avs_writedata_i[led_pkg::IRQ_WIDTH-1:0];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_q <= '0;
        end else if (avs_write_i && ack_q && avs_address_i == led_pkg::IRQ_STAT_OFS && avs_byteenable_i[0]) begin
            irq_stat_q <= (irq_stat_q & ~avs_writedata_i[led_pkg::IRQ_WIDTH-1:0]) | evt_d;
        end else begin
            irq_stat_q <= irq_stat_q | evt_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack_q) begin
            unique case (avs_address_i)
                led_pkg::CTRL_OFS: avs_readdata_o <= ctrl_q;
                led_pkg::STAT_OFS: avs_readdata_o <= {16'h0, sync2_q};
                led_pkg::IRQ_STAT_OFS: avs_readdata_o <= {28'h0, irq_stat_q};
                led_pkg::IRQ_MASK_OFS: avs_readdata_o <= {28'h0, irq_mask_q};
                default: avs_readdata_o <= 32'h0;
            endcase
        end
    end
endmodule

/* testbench/led_chk.sv */
`timescale 1ns/100ps
module led_chk #(
    parameter int TICK_CYCLES = 2
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Watched ports
    input wire led_pkg::status_s status_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire led_pkg::leds_s leds_o,
    input wire logic outputs_safe_o,
    input wire logic irq_o
);
    logic [2:0] up_q;
    logic [47:0] s_q;
    wire led_pkg::status_s s = s_q[47:32];
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Lamps lag the pins by two sync stages and an output flop
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_q <= 3'h0;
            s_q <= '0;
        end else begin
            up_q <= {up_q[1:0], 1'b1};
            s_q <= {s_q[31:0], status_i};
        end
    end
    pass_leds_a: assert property (up_q[2] |-> leds_o[14:8] == s[15:9]) else $error("pass");
    drive_dir_a: assert property (up_q[2] |-> {leds_o.drv, leds_o[5:4]} == {s.drv_ready, s[6:5]}) else $error("dir");
    fault_leds_a: assert property (up_q[2] |-> leds_o[2:0] == {!s[7] | s[3] | s[2], s[1:0]}) else $error("flt");
    power_gate_a: assert property (up_q[2] && leds_o.pwr |-> s.supply_ok) else $error("pwr");
    enable_gate_a: assert property (up_q[2] && leds_o.en |-> s.mod_ready) else $error("en");
    run_steady_a: assert property (!outputs_safe_o [*4] |-> leds_o.run) else $error("run");
    wait_first_a: assert property ((avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i)
        |-> avs_waitrequest_o) else $error("wait");
    wait_once_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait2");
    cover property (leds_o.run ##1 !leds_o.run);
    cover property (irq_o);
    cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind status_led_driver led_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

/* testbench/led_panel_model.sv */
`timescale 1ns/100ps
module led_panel_model (
    // Clock and lamps
    input wire logic clk_i,
    input wire led_pkg::leds_s leds_i,
    // Lit time of the run lamp
    output int run_lit_o
);
    // An eye only integrates glow, so lit cycles are all that count
    always_ff @(posedge clk_i) begin
        if (leds_i.run === 1'b1) begin
            run_lit_o <= run_lit_o + 1;
        end
    end
endmodule

/* testbench/stepper_status_led_driver_tb.sv */
`timescale 1ns/100ps
module stepper_status_led_driver_tb;
    localparam int PER = 2 * led_pkg::FLASH_PERIOD_MS;
    localparam int FL = 2 * led_pkg::FLASH_ON_MS;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, en;
    logic [3:0] ad = 4'h0;
    logic [31:0] wd = 32'h0, rdat, q;
    logic wrq, safe, irq;
    led_pkg::status_s st = '0;
    led_pkg::leds_s leds;
    int lit, n, err_count = 0, comparisons = 0, seed = 32'h26dae3a2;
    always #10 clk = ~clk;
    status_led_driver #(.TICK_CYCLES(2)) u_dut (.core_clk_i(clk), .arst_n_i(rst_n), .status_i(st),
        .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .leds_o(leds), .outputs_safe_o(safe), .irq_o(irq));
    led_panel_model u_panel (.clk_i(clk), .leds_i(leds), .run_lit_o(lit));
    task automatic report_and_stop();
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %0t: %h not %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {rd, wr, ad, wd} <= {!w, w, a, d};
        do @(posedge clk); while (wrq !== 1'b0);
        q = rdat;
        {rd, wr} <= 2'h0;
    endtask
    function automatic logic [31:0] model(led_pkg::status_s s, logic e);
        return {16'h0, 1'b0, s[15:8], s.supply_ok & e, s[6:5], e & s.mod_ready, !s[7] | s[3] | s[2], s[1:0]};
    endfunction
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, led_pkg::CTRL_OFS, 32'h0);
        chk(q, led_pkg::CTRL_RESET);
        bus(1'b0, 4'h1, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 16; i++) begin
            en = 1'($random(seed));
            st <= 16'($random(seed));
            bus(1'b1, led_pkg::CTRL_OFS, {25'h0, 3'(i % 5), 3'h0, en});
            repeat (4) @(posedge clk);
            chk(32'(leds & 16'h7fff), model(st, en));
            chk(32'(safe), 32'(i % 5 != 0));
        end
        // A whole pattern period makes the lit count exact
        for (int r = 0; r < 6; r++) begin
            bus(1'b1, led_pkg::CTRL_OFS, 32'(r * 16 + 1));
            repeat (8) @(posedge clk);
            n = lit;
            repeat (PER) @(posedge clk);
            chk(32'(lit - n), 32'(r == 0 ? PER : r == 2 ? PER / 2 : r == 4 ? FL : 0));
        end
        st <= 16'h0080;
        bus(1'b1, led_pkg::IRQ_MASK_OFS, 32'hf);
        repeat (4) @(posedge clk);
        bus(1'b1, led_pkg::IRQ_STAT_OFS, 32'hf);
        st <= 16'h0082;
        repeat (5) @(posedge clk);
        bus(1'b0, led_pkg::IRQ_STAT_OFS, 32'h0);
        chk(q, 32'h1 << led_pkg::IRQ_ERR_A_BIT);
        chk(32'(irq), 32'h1);
        bus(1'b1, led_pkg::IRQ_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        bus(1'b1, led_pkg::IRQ_STAT_OFS, 32'hf);
        bus(1'b0, led_pkg::IRQ_STAT_OFS, 32'h0);
        chk(q, 32'h0);
        report_and_stop();
    end
    initial begin
        #800000;
        err_count++;
        report_and_stop();
    end
endmodule
